// *** shared/sct_pkg.sv ***
// Purpose: Shared constants and types for the command-transport log decoder and its host end.
// Assumes: One clock, synchronous active-high reset.
// Notes: Status page is streamed as 16-bit words, low byte first on the wire order of the page.
package sct_pkg;
  localparam logic [7:0] SCT_CMD_SMART = 8'hB0;
  localparam logic [7:0] SCT_CMD_LOG_RD = 8'h2F;
  localparam logic [7:0] SCT_CMD_LOG_WR = 8'h3F;
  localparam logic [7:0] SCT_FEAT_RD = 8'hD5;
  localparam logic [7:0] SCT_FEAT_WR = 8'hD6;
  localparam logic [7:0] SCT_SIG_LO = 8'h4F;
  localparam logic [7:0] SCT_SIG_HI = 8'hC2;
  localparam logic [7:0] SCT_PAGE_STATUS = 8'hE0;
  localparam logic [7:0] SCT_PAGE_DATA = 8'hE1;
  localparam logic [7:0] SCT_ONE = 8'h01;
  localparam logic [7:0] SCT_ZERO = 8'h00;
  localparam logic [15:0] SCT_FORMAT_VER = 16'h0003;
  localparam logic [15:0] SCT_SPEC_VER = 16'h0001;
  localparam logic [15:0] SCT_EXT_BUSY = 16'hFFFF;
  localparam int SCT_WORDS_PER_SECTOR = 256;
  localparam int SCT_IDX_FMT = 0;
  localparam int SCT_IDX_IMPL = 1;
  localparam int SCT_IDX_SPEC = 2;
  localparam int SCT_IDX_FLAG_LO = 3;
  localparam int SCT_IDX_FLAG_HI = 4;
  localparam int SCT_IDX_STATE = 5;
  localparam int SCT_IDX_EXT = 7;
  localparam int SCT_IDX_ACTION = 8;
  localparam int SCT_IDX_FUNC = 9;

  typedef enum logic [2:0]
  {
    SCT_DS_IDLE = 3'h0,
    SCT_DS_STANDBY = 3'h1,
    SCT_DS_SLEEP = 3'h2,
    SCT_DS_SELFTEST = 3'h3,
    SCT_DS_OFFLINE = 3'h4,
    SCT_DS_SCT = 3'h5
  } sct_drive_state_t;

  typedef enum logic [1:0]
  {
    SCT_ACK_NONE = 2'h0,
    SCT_ACK_OK = 2'h1,
    SCT_ACK_ERR = 2'h2
  } sct_ack_t;

  // Command block as the host places it in the task-file registers.
  typedef struct packed {
    logic [7:0] command;
    logic [7:0] feature;
    logic [7:0] count_cur;
    logic [7:0] count_prev;
    logic [7:0] lba_low;
    logic [7:0] lba_mid_cur;
    logic [7:0] lba_mid_prev;
    logic [7:0] lba_high;
  } sct_taskfile_t;
endpackage

// *** shared/sct_if.sv ***
// Purpose: Register-level link between host controller and drive logic.
// Assumes: Both ends on core_clk.
// Notes: Data words flow in either direction with valid/ready.
interface sct_if;
  import sct_pkg::*;
  sct_taskfile_t tf;
  logic tf_valid;
  logic tf_ready;
  sct_ack_t ack;
  logic [15:0] rd_data;
  logic rd_valid;
  logic rd_ready;
  logic [15:0] wr_data;
  logic wr_valid;
  logic wr_ready;

  modport device (input tf, input tf_valid, output tf_ready, output ack,
    output rd_data, output rd_valid, input rd_ready,
    input wr_data, input wr_valid, output wr_ready);
  modport host (output tf, output tf_valid, input tf_ready, input ack,
    input rd_data, input rd_valid, output rd_ready,
    output wr_data, output wr_valid, input wr_ready);
endinterface

// *** hw/sct_fifo.sv ***
// Purpose: Parameterised synchronous FIFO with valid/ready on both sides.
// Assumes: One clock, synchronous reset.
// Notes: Full and empty are exact; no bypass path.
module sct_fifo
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } sct_fifo_st_t;
  sct_fifo_st_t st_reg;
  sct_fifo_st_t st_next;
  logic push;
  logic pop;

  assign in_ready = st_reg.cnt != (AW+1)'(DEPTH);
  assign out_valid = st_reg.cnt != '0;
  assign out_data = mem[st_reg.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    st_next = st_reg;
    if (push)
      st_next.wp = (st_reg.wp == AW'(DEPTH - 1)) ? '0 : st_reg.wp + 1'b1;
    if (pop)
      st_next.rp = (st_reg.rp == AW'(DEPTH - 1)) ? '0 : st_reg.rp + 1'b1;
    if (push && !pop)
      st_next.cnt = st_reg.cnt + 1'b1;
    else if (pop && !push)
      st_next.cnt = st_reg.cnt - 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      st_reg <= '0;
    else
      st_reg <= st_next;
    if (push)
      mem[st_reg.wp] <= in_data;
  end
endmodule

// *** hw/sct_device.sv ***
// Purpose: Drive-side decoder for command-transport data and status log requests.
// Assumes: Host keeps each command block stable while tf_valid is high.
// Notes: Written data sectors are buffered in a FIFO; read words pass one register; the status page is built on the fly.

// Functional notes
// R1 - SMART data transfer: B0h, D5h/D6h, C2h/4Fh, E1h.
// R2 - SMART sector count sets sectors moved.
// R3 - Log ext data: 2Fh/3Fh, E1h, count 0001h, mid zero.
// R4 - ATA ack only means accepted or rejected.
// R5 - Host polls status page for progress.
// R6 - Status information lives in log page E0h.
// R7 - Status served even during background action.
// R8 - Status read keeps power state and background work.
// R9 - SMART status: B0h D5h count 01h E0h signature.
// R10 - Log ext status: 2Fh, E0h, count 0001h, mid zero.
// R11 - Page bytes 1:0 hold format 0003h.
// R12 - Bytes 5:4 spec 0001h; 3:2 implementation.
// R13 - Flag bit0 set after full fill write.
// R14 - Any user LBA write clears flag.
// R15 - Capacity change clears flag; kept otherwise.
// R16 - Byte 10 encodes the drive state.
// R17 - Bytes 15:14 extended status, FFFFh while busy.
// R18 - Bytes 17:16, 19:18 action and function code.
module sct_device
import sct_pkg::*;
#(
  parameter int FIFO_DEPTH = 16,
  parameter logic [15:0] IMPL_VERSION = 16'h0100 // Arbitrary value.
)
(
  input wire logic core_clk,
  input wire logic rst,
  sct_if.device link,
  input wire logic [2:0] drive_state,
  input wire logic fill_done,
  input wire logic user_lba_write,
  input wire logic max_address_set,
  input wire logic max_address_set_extended,
  input wire logic configuration_overlay,
  input wire logic flag_saved,
  input wire logic flag_load,
  input wire logic [15:0] ext_status,
  input wire logic [15:0] action_code,
  input wire logic [15:0] function_code,
  output logic [15:0] data_out,
  output logic data_out_valid,
  input wire logic data_out_ready,
  input wire logic [15:0] data_in,
  input wire logic data_in_valid,
  output logic data_in_ready,
  output logic seg_init_flag,
  output logic xfer_busy
);
  typedef enum logic [1:0]
  {
    SCT_ST_IDLE = 2'b00,
    SCT_ST_STATUS = 2'b01,
    SCT_ST_RD = 2'b10,
    SCT_ST_WR = 2'b11
  } sct_dev_fsm_t;

  typedef struct packed {
    sct_dev_fsm_t fsm;
    logic [16:0] words_left;
    logic [7:0] idx;
    logic flag;
    sct_ack_t ack;
    logic [15:0] rd_data;
    logic rd_valid;
  } sct_dev_st_t;

  sct_dev_st_t st_reg;
  sct_dev_st_t st_next;
  logic [15:0] wfifo_data;
  logic wfifo_valid;
  logic wfifo_ready;
  logic smart_sig;
  logic ext_ok;
  logic [2:0] kind;

  ////////////////////////////////////////////////////////////////////////////
  // Command block decode.

  // Returns the page word at a given index; the rest of the page reads zero.
  function automatic logic [15:0] page_word(input logic [7:0] i, input logic flag,
    input logic [2:0] ds, input logic [15:0] ext, input logic [15:0] act, input logic [15:0] fn);
    logic [15:0] w;
    w = '0;
    case (i)
      8'(SCT_IDX_FMT): w = SCT_FORMAT_VER; // [R11] [R6]
      8'(SCT_IDX_IMPL): w = IMPL_VERSION; // [R12]
      8'(SCT_IDX_SPEC): w = SCT_SPEC_VER; // [R12]
      8'(SCT_IDX_FLAG_LO): w = {15'h0000, flag}; // [R13]
      8'(SCT_IDX_FLAG_HI): w = '0;
      8'(SCT_IDX_STATE): w = {13'h0000, ds}; // [R16]
      8'(SCT_IDX_EXT): w = (ds == SCT_DS_SCT) ? SCT_EXT_BUSY : ext; // [R17]
      8'(SCT_IDX_ACTION): w = act; // [R18]
      8'(SCT_IDX_FUNC): w = fn; // [R18]
      default: w = '0;
    endcase
    return w;
  endfunction

  assign smart_sig = link.tf.command == SCT_CMD_SMART && link.tf.lba_mid_cur == SCT_SIG_LO
    && link.tf.lba_high == SCT_SIG_HI; // [R1] [R9]
  assign ext_ok = link.tf.count_cur == SCT_ONE && link.tf.count_prev == SCT_ZERO
    && link.tf.lba_mid_cur == SCT_ZERO && link.tf.lba_mid_prev == SCT_ZERO; // [R3] [R10]

  // Kind: 1 status, 2 data read, 3 data write, 0 rejected.
  always_comb
  begin
    kind = 3'h0;
    if (smart_sig && link.tf.feature == SCT_FEAT_RD && link.tf.lba_low == SCT_PAGE_STATUS
        && link.tf.count_cur == SCT_ONE)
      kind = 3'h1; // [R9]
    else if (smart_sig && link.tf.lba_low == SCT_PAGE_DATA && link.tf.count_cur != SCT_ZERO)
    begin
      if (link.tf.feature == SCT_FEAT_RD)
        kind = 3'h2; // [R1]
      else if (link.tf.feature == SCT_FEAT_WR)
        kind = 3'h3; // [R1]
    end
    else if (ext_ok && link.tf.command == SCT_CMD_LOG_RD && link.tf.lba_low == SCT_PAGE_STATUS)
      kind = 3'h1; // [R10]
    else if (ext_ok && link.tf.lba_low == SCT_PAGE_DATA)
    begin
      if (link.tf.command == SCT_CMD_LOG_RD)
        kind = 3'h2; // [R3]
      else if (link.tf.command == SCT_CMD_LOG_WR)
        kind = 3'h3; // [R3]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Incoming sector data passes the FIFO so the user side can stall the host.

  sct_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_wfifo
  (
    .core_clk(core_clk),
    .rst(rst),
    .in_data(link.wr_data),
    .in_valid(link.wr_valid && st_reg.fsm == SCT_ST_WR),
    .in_ready(wfifo_ready),
    .out_data(wfifo_data),
    .out_valid(wfifo_valid),
    .out_ready(data_out_ready)
  );

  assign link.wr_ready = wfifo_ready && st_reg.fsm == SCT_ST_WR;
  assign link.tf_ready = st_reg.fsm == SCT_ST_IDLE && st_reg.ack == SCT_ACK_NONE;
  assign link.ack = st_reg.ack;
  assign link.rd_data = st_reg.rd_data;
  assign link.rd_valid = st_reg.rd_valid;
  assign data_out = wfifo_data;
  assign data_out_valid = wfifo_valid;
  assign data_in_ready = st_reg.fsm == SCT_ST_RD && (!st_reg.rd_valid || link.rd_ready);
  assign seg_init_flag = st_reg.flag;
  assign xfer_busy = st_reg.fsm != SCT_ST_IDLE;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing. Nothing here drives the power state or background work.

  always_comb
  begin
    st_next = st_reg;
    st_next.ack = SCT_ACK_NONE; // [R4]
    if (st_reg.rd_valid && link.rd_ready)
      st_next.rd_valid = 1'b0;
    // A clearing event wins over completion of a fill, since data is then stale.
    if (flag_load)
      st_next.flag = flag_saved; // [R15]
    else if (fill_done)
      st_next.flag = 1'b1; // [R13]
    if (user_lba_write)
      st_next.flag = 1'b0; // [R14]
    if (max_address_set || max_address_set_extended || configuration_overlay)
      st_next.flag = 1'b0; // [R15]
    case (st_reg.fsm)
      SCT_ST_IDLE:
      begin
        if (link.tf_valid && link.tf_ready)
        begin
          // Accept only reports the decode result, never completion of the action.
          st_next.ack = (kind == 3'h0) ? SCT_ACK_ERR : SCT_ACK_OK; // [R4]
          st_next.idx = '0;
          st_next.words_left = 17'(link.tf.count_cur) * 17'(SCT_WORDS_PER_SECTOR); // [R2]
          case (kind)
            3'h1: st_next.fsm = SCT_ST_STATUS; // [R7] [R8]
            3'h2: st_next.fsm = SCT_ST_RD;
            3'h3: st_next.fsm = SCT_ST_WR;
            default: st_next.fsm = SCT_ST_IDLE;
          endcase
          if (kind == 3'h1)
            st_next.words_left = 17'(SCT_WORDS_PER_SECTOR); // [R9] [R10]
        end
      end
      SCT_ST_STATUS:
      begin
        if (!st_reg.rd_valid || link.rd_ready)
        begin
          st_next.rd_data = page_word(st_reg.idx, st_reg.flag, drive_state, ext_status,
            action_code, function_code); // [R6]
          st_next.rd_valid = 1'b1;
          st_next.idx = st_reg.idx + 8'h01;
          st_next.words_left = st_reg.words_left - 17'h00001;
          if (st_reg.words_left == 17'h00001)
            st_next.fsm = SCT_ST_IDLE;
        end
      end
      SCT_ST_RD:
      begin
        if (data_in_valid && data_in_ready)
        begin
          st_next.rd_data = data_in; // [R2]
          st_next.rd_valid = 1'b1;
          st_next.words_left = st_reg.words_left - 17'h00001;
          if (st_reg.words_left == 17'h00001)
            st_next.fsm = SCT_ST_IDLE;
        end
      end
      SCT_ST_WR:
      begin
        if (link.wr_valid && link.wr_ready)
        begin
          st_next.words_left = st_reg.words_left - 17'h00001; // [R2]
          if (st_reg.words_left == 17'h00001)
            st_next.fsm = SCT_ST_IDLE;
        end
      end
      default: st_next.fsm = SCT_ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      st_reg <= '{fsm: SCT_ST_IDLE, ack: SCT_ACK_NONE, default: '0};
    else
      st_reg <= st_next;
  end
endmodule

// *** hw/sct_host.sv ***
// Purpose: Host-side end that issues command blocks and moves sector words.
// Assumes: User holds request fields stable while req is high.
// Notes: Status polling is just another read request of the status page.

module sct_host
import sct_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  sct_if.host link,
  input wire logic req,
  input wire logic use_ext,
  input wire logic is_status,
  input wire logic is_write,
  input wire logic [7:0] sectors,
  output logic req_ready,
  output logic done,
  output logic error,
  output logic [15:0] rdata,
  output logic rdata_valid,
  input wire logic [15:0] wdata,
  input wire logic wdata_valid,
  output logic wdata_ready
);
  typedef enum logic [1:0]
  {
    SCT_H_IDLE = 2'b00,
    SCT_H_WAIT = 2'b01,
    SCT_H_XFER = 2'b10
  } sct_host_fsm_t;

  typedef struct packed {
    sct_host_fsm_t fsm;
    sct_taskfile_t tf;
    logic tf_valid;
    logic wr;
    logic done;
    logic error;
    logic [15:0] rdata;
    logic rdata_valid;
  } sct_host_st_t;

  sct_host_st_t st_reg;
  sct_host_st_t st_next;

  assign link.tf = st_reg.tf;
  assign link.tf_valid = st_reg.tf_valid;
  assign link.rd_ready = st_reg.fsm == SCT_H_XFER && !st_reg.wr;
  assign link.wr_data = wdata;
  assign link.wr_valid = wdata_valid && st_reg.fsm == SCT_H_XFER && st_reg.wr;
  assign wdata_ready = link.wr_ready && st_reg.fsm == SCT_H_XFER && st_reg.wr;
  assign req_ready = st_reg.fsm == SCT_H_IDLE;
  assign done = st_reg.done;
  assign error = st_reg.error;
  assign rdata = st_reg.rdata;
  assign rdata_valid = st_reg.rdata_valid;

  always_comb
  begin
    st_next = st_reg;
    st_next.done = 1'b0;
    st_next.error = 1'b0;
    st_next.rdata_valid = 1'b0;
    case (st_reg.fsm)
      SCT_H_IDLE:
      begin
        if (req)
        begin
          st_next.tf = '0;
          st_next.wr = is_write && !is_status;
          st_next.tf.lba_low = is_status ? SCT_PAGE_STATUS : SCT_PAGE_DATA; // [R6]
          if (use_ext)
          begin
            st_next.tf.command = (is_write && !is_status) ? SCT_CMD_LOG_WR : SCT_CMD_LOG_RD; // [R3] [R10]
            st_next.tf.count_cur = SCT_ONE;
          end
          else
          begin
            st_next.tf.command = SCT_CMD_SMART; // [R1] [R9]
            st_next.tf.feature = (is_write && !is_status) ? SCT_FEAT_WR : SCT_FEAT_RD;
            st_next.tf.count_cur = is_status ? SCT_ONE : sectors; // [R2]
            st_next.tf.lba_mid_cur = SCT_SIG_LO;
            st_next.tf.lba_high = SCT_SIG_HI;
          end
          st_next.tf_valid = 1'b1;
          st_next.fsm = SCT_H_WAIT;
        end
      end
      SCT_H_WAIT:
      begin
        if (link.tf_ready)
          st_next.tf_valid = 1'b0;
        if (link.ack == SCT_ACK_ERR)
        begin
          st_next.error = 1'b1;
          st_next.done = 1'b1;
          st_next.fsm = SCT_H_IDLE;
        end
        else if (link.ack == SCT_ACK_OK)
          st_next.fsm = SCT_H_XFER;
      end
      SCT_H_XFER:
      begin
        // Progress of long actions is seen only through repeated status reads.
        if (!st_reg.wr && link.rd_valid)
        begin
          st_next.rdata = link.rd_data; // [R5]
          st_next.rdata_valid = 1'b1;
        end
        if (link.tf_ready)
        begin
          st_next.done = 1'b1;
          st_next.fsm = SCT_H_IDLE;
        end
      end
      default: st_next.fsm = SCT_H_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      st_reg <= '{fsm: SCT_H_IDLE, default: '0};
    else
      st_reg <= st_next;
  end
endmodule

// *** verification/sct_link_properties.sv ***
// Purpose: Protocol checker for the command link between host and drive ends.
// Assumes: One clock, synchronous active-high reset.
// Notes: Word index counts read words taken since the last command.
module sct_link_properties
import sct_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire sct_taskfile_t tf,
  input wire logic tf_valid,
  input wire logic tf_ready,
  input wire sct_ack_t ack,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid,
  input wire logic rd_ready,
  input wire logic [15:0] wr_data,
  input wire logic wr_valid,
  input wire logic wr_ready
);
  logic stat_reg;
  logic [8:0] idx_reg;
  wire logic take = tf_valid && tf_ready;
  wire logic sig = tf.lba_mid_cur == SCT_SIG_LO && tf.lba_high == SCT_SIG_HI;
  wire logic ext_ok = tf.count_cur == SCT_ONE && tf.count_prev == SCT_ZERO
    && tf.lba_mid_cur == SCT_ZERO && tf.lba_mid_prev == SCT_ZERO;
  wire logic smart_rw = tf.command == SCT_CMD_SMART && (tf.feature == SCT_FEAT_RD || tf.feature == SCT_FEAT_WR);
  wire logic ext_rw = tf.command == SCT_CMD_LOG_RD || tf.command == SCT_CMD_LOG_WR;
  wire logic stat_word = stat_reg && rd_valid;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      stat_reg <= 1'b0;
      idx_reg <= 9'h000;
    end
    else if (take)
    begin
      stat_reg <= tf.lba_low == SCT_PAGE_STATUS;
      idx_reg <= 9'h000;
    end
    else if (rd_valid && rd_ready)
    begin
      idx_reg <= idx_reg + 9'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence s_smart_stat;
    take && tf.command == SCT_CMD_SMART && tf.feature == SCT_FEAT_RD && tf.count_cur == SCT_ONE
      && tf.lba_low == SCT_PAGE_STATUS && sig;
  endsequence
  sequence s_ext_stat;
    take && tf.command == SCT_CMD_LOG_RD && tf.lba_low == SCT_PAGE_STATUS && ext_ok;
  endsequence
  sequence s_smart_data;
    take && smart_rw && tf.lba_low == SCT_PAGE_DATA && sig;
  endsequence
  sequence s_answer;
    (ack != SCT_ACK_NONE) ##1 (ack == SCT_ACK_NONE);
  endsequence

  a_ack_answer: assert property (take |=> s_answer) else $error("ack not a single cycle after take");
  a_ack_cause: assert property (ack != SCT_ACK_NONE |-> $past(take)) else $error("ack without command");
  a_smart_stat_ok: assert property (s_smart_stat |=> ack == SCT_ACK_OK) else $error("status refused");
  a_ext_stat_ok: assert property (s_ext_stat |=> ack == SCT_ACK_OK) else $error("ext status refused");
  a_ext_data_ok: assert property (take && ext_rw && tf.lba_low == SCT_PAGE_DATA && ext_ok |=> ack == SCT_ACK_OK)
    else $error("ext data refused");
  a_smart_data_ok: assert property (s_smart_data ##0 tf.count_cur != SCT_ZERO |=> ack == SCT_ACK_OK)
    else $error("data refused");
  a_zero_count_err: assert property (s_smart_data ##0 tf.count_cur == SCT_ZERO |=> ack == SCT_ACK_ERR)
    else $error("zero count accepted");
  a_fmt_word: assert property (stat_word && idx_reg == 9'h000 |-> rd_data == SCT_FORMAT_VER)
    else $error("bad format word");
  a_spec_word: assert property (stat_word && idx_reg == 9'h002 |-> rd_data == SCT_SPEC_VER)
    else $error("bad spec word");
  a_flag_reserved: assert property (stat_word && idx_reg == 9'h003 |-> rd_data[15:1] == 15'h0000)
    else $error("reserved flag bits set");
  a_state_code: assert property (stat_word && idx_reg == 9'h005 |-> rd_data <= 16'h0005)
    else $error("bad state code");
  a_page_len: assert property (stat_reg && rd_valid && rd_ready |-> idx_reg <= 9'h0FF)
    else $error("status page too long");
  a_wr_hold: assert property (wr_valid && !wr_ready && !tf_ready |=> wr_valid && $stable(wr_data))
    else $error("write word dropped while stalled");
endmodule

// *** verification/test_sct_log_transfer_and_status.sv ***
// Purpose: Self-checking bench joining host and drive ends over the link.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes: Data words are counters so loss or reordering shows at once.
module test_sct_log_transfer_and_status import sct_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] IMPL = 16'h0A5C; // Arbitrary value.
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic req, use_ext, is_status, is_write, req_ready, done, error, rdata_valid, wdata_valid, wdata_ready;
  logic [7:0] sectors;
  logic [15:0] rdata, wdata, ext_status, action_code, function_code, data_out, data_in, rd_exp, out_exp;
  logic [2:0] drive_state;
  logic [5:0] ev;
  logic flag_saved, data_out_valid, data_out_ready, data_in_valid, data_in_ready, seg_init_flag, xfer_busy;
  logic in_stat;
  logic [15:0] page [0:9];
  int rd_n;
  int fails = 0;
  int checks = 0;
  sct_taskfile_t last_tf;

  always #5 core_clk = ~core_clk;

  sct_if link_if ();
  sct_host sct_host_inst (.core_clk, .rst, .link(link_if), .req, .use_ext, .is_status, .is_write,
    .sectors, .req_ready, .done, .error, .rdata, .rdata_valid, .wdata, .wdata_valid, .wdata_ready);
  sct_device #(.FIFO_DEPTH(16), .IMPL_VERSION(IMPL)) sct_device_inst (.core_clk, .rst, .link(link_if),
    .drive_state, .fill_done(ev[0]), .user_lba_write(ev[1]), .max_address_set(ev[2]),
    .max_address_set_extended(ev[3]), .configuration_overlay(ev[4]), .flag_saved, .flag_load(ev[5]),
    .ext_status, .action_code, .function_code, .data_out, .data_out_valid, .data_out_ready,
    .data_in, .data_in_valid, .data_in_ready, .seg_init_flag, .xfer_busy);
  sct_link_properties sct_link_properties_inst (.core_clk, .rst, .tf(link_if.tf), .tf_valid(link_if.tf_valid),
    .tf_ready(link_if.tf_ready), .ack(link_if.ack), .rd_data(link_if.rd_data), .rd_valid(link_if.rd_valid),
    .rd_ready(link_if.rd_ready), .wr_data(link_if.wr_data), .wr_valid(link_if.wr_valid),
    .wr_ready(link_if.wr_ready));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task finish_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Source counters advance only on words really taken, so both sides stay in step.
  always @(posedge core_clk)
  begin
    data_in <= #1 data_in + 16'(data_in_valid && data_in_ready);
    wdata <= #1 wdata + 16'(wdata_valid && wdata_ready);
    if (link_if.tf_valid && link_if.tf_ready)
      last_tf = link_if.tf;
    if (data_out_valid === 1'b1 && data_out_ready)
    begin
      chk("data_out", data_out, out_exp);
      out_exp++;
    end
    if (rdata_valid === 1'b1)
    begin
      if (!in_stat)
      begin
        chk("rdata", rdata, rd_exp);
        rd_exp++;
      end
      else if (rd_n < 10)
        page[rd_n] = rdata;
      rd_n++;
    end
  end

  task automatic pulse(input int k);
    @(posedge core_clk);
    #1 ev = 6'h01 << k;
    @(posedge core_clk);
    #1 ev = 6'h00;
  endtask

  task automatic do_req(input logic ext, st, wr, input logic [7:0] sec, output logic err);
    int n;
    use_ext = ext;
    is_status = st;
    is_write = wr;
    sectors = sec;
    req = 1'b1;
    n = 0;
    while (req_ready !== 1'b1 && n < 100)
    begin
      @(posedge core_clk);
      #1 n++;
    end
    if (n >= 100)
    begin
      fails++;
      finish_test;
    end
    @(posedge core_clk);
    #1 req = 1'b0;
    while (done !== 1'b1 && error !== 1'b1 && n < 3000)
    begin
      @(posedge core_clk);
      #1 n++;
    end
    err = error;
    if (n >= 3000)
    begin
      fails++;
      finish_test;
    end
    repeat (20) @(posedge core_clk);
    #1;
  endtask

  task automatic t_flags;
    pulse(0);
    chk("flag_set", {15'h0, seg_init_flag}, 16'h0001);
    pulse(1);
    chk("flag_write", {15'h0, seg_init_flag}, 16'h0000);
    for (int k = 2; k < 5; k++)
    begin
      pulse(0);
      pulse(k);
      chk("flag_capacity", {15'h0, seg_init_flag}, 16'h0000);
    end
    flag_saved = 1'b1;
    pulse(5);
    chk("flag_restore", {15'h0, seg_init_flag}, 16'h0001);
    $display("test flags done");
  endtask

  task automatic t_status(input logic ext, input logic [2:0] st);
    logic err;
    logic [15:0] exp [0:9];
    drive_state = st;
    // The page must report busy in state 5 whatever the last completion code says.
    ext_status = {13'h0, st};
    action_code = 16'h0002 + 16'(st);
    function_code = 16'h0010 + 16'(st);
    exp = '{SCT_FORMAT_VER, IMPL, SCT_SPEC_VER, 16'h0001, 16'h0000, {13'h0, st}, 16'h0000,
      (st == 3'h5) ? SCT_EXT_BUSY : ext_status, action_code, function_code};
    in_stat = 1'b1;
    rd_n = 0;
    do_req(ext, 1'b1, 1'b0, 8'h01, err);
    for (int i = 0; i < 10; i++)
      chk("status_word", page[i], exp[i]);
    chk("status_len", 16'(rd_n), 16'h0100);
    chk("page_sel", {8'h00, last_tf.lba_low}, {8'h00, SCT_PAGE_STATUS});
    chk("flag_kept", {15'h0, seg_init_flag}, 16'h0001);
    chk("status_err", {15'h0, err}, 16'h0000);
    $display("test status %0d done", st);
  endtask

  task automatic t_data(input logic ext, wr, input logic [7:0] sec);
    logic err;
    logic [15:0] r0, o0;
    r0 = rd_exp;
    o0 = out_exp;
    in_stat = 1'b0;
    data_out_ready = !wr;
    fork
      do_req(ext, 1'b0, wr, sec, err);
      begin
        repeat (40) @(posedge core_clk);
        #1;
        // With the media side stalled the 16-word buffer must refuse more words.
        if (wr)
          chk("fifo_full", {15'h0, wdata_ready}, 16'h0000);
        chk("busy", {15'h0, xfer_busy}, {15'h0, sec != 8'h00});
        data_out_ready = 1'b1;
      end
    join
    chk("words", wr ? out_exp - o0 : rd_exp - r0, {sec, 8'h00});
    chk("data_err", {15'h0, err}, {15'h0, sec == 8'h00});
    $display("test data ext %0d write %0d sectors %0d done", ext, wr, sec);
  endtask

  initial
  begin
    {req, use_ext, is_status, is_write, sectors, ev, flag_saved, drive_state} = '0;
    {wdata, ext_status, action_code, function_code, data_in, rd_exp, out_exp} = '0;
    {wdata_valid, data_in_valid, data_out_ready, in_stat, rd_n} = {3'b111, 1'b0, 32'd0};
    repeat (20) @(posedge core_clk);
    #1 rst = 1'b0;
    t_flags();
    for (int s = 0; s < 6; s++)
      t_status(s[0], 3'(s));
    t_data(1'b0, 1'b0, 8'h02);
    t_data(1'b0, 1'b1, 8'h02);
    t_data(1'b1, 1'b0, 8'h01);
    t_data(1'b1, 1'b1, 8'h01);
    t_data(1'b0, 1'b0, 8'h00);
    finish_test();
  end
endmodule
